// *** hdl/apt_card.sv ***
// card end: splits incoming messages into header and data for the
// card application and returns its data and status, with procedure bytes on the character protocol
// assumes the application answers on the same clock and that rdData
// follows rdAddr within the same cycle
`timescale 1ns/1ps
`default_nettype none
module apt_card
  import apt_pkg::*;
#(
  parameter int BLK_LEN = BLK_MAX
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // protocol select
  input wire logic useT1,
  // link to the terminal end
  apt_link_if.card link,
  // command to the application
  output logic hdrValid,
  output logic [39:0] hdrBytes,
  output logic cdValid,
  output logic [7:0] cdData,
  output logic dataDone,
  // answers from the application
  input wire logic ansValid,
  input wire logic [2:0] ansCase,
  input wire logic [15:0] ansSw,
  input wire logic [8:0] ansLen,
  // response data fetch
  output logic [8:0] rdAddr,
  input wire logic [7:0] rdData
);

  typedef enum logic [3:0] {
    C_HDR = 4'b0000,
    C_APP = 4'b0001,
    C_DEC = 4'b0010,
    C_DIN = 4'b0011,
    C_FIN = 4'b0100,
    C_DOUT = 4'b0101,
    C_TX = 4'b0110,
    C_T1APP = 4'b0111,
    C_T1TX = 4'b1000
  } apt_cstate_t;

  apt_cstate_t state_reg;
  apt_cstate_t txNext_reg;
  logic [8:0] cnt_reg;
  logic [8:0] blk_reg;
  logic [8:0] left_reg;
  logic [8:0] avail_reg;
  logic [8:0] base_reg;
  logic [8:0] pendLen_reg;
  logic [15:0] pendSw_reg;
  logic [15:0] sw_reg;
  logic [2:0] caseNum_reg;
  logic [15:0] tx_reg;
  logic [15:0] tail_reg;
  logic txTwo_reg;
  logic c2tValid_reg;
  logic [7:0] c2tData_reg;
  logic c2tEnd_reg;
  logic c2tMore_reg;
  logic [8:0] le;

  assign link.c2tValid = c2tValid_reg;
  assign link.c2tData = c2tData_reg;
  assign link.c2tEnd = c2tEnd_reg;
  assign link.c2tMore = c2tMore_reg;
  assign le = leOf(hdrBytes[7:0]);

  // command, answer and response sequencing
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= C_HDR;
      txNext_reg <= C_HDR;
      cnt_reg <= 9'h000;
      blk_reg <= 9'h000;
      left_reg <= 9'h000;
      avail_reg <= 9'h000;
      base_reg <= 9'h000;
      pendLen_reg <= 9'h000;
      pendSw_reg <= 16'h0000;
      sw_reg <= 16'h0000;
      caseNum_reg <= 3'd0;
      tx_reg <= 16'h0000;
      tail_reg <= 16'h0000;
      txTwo_reg <= 1'b0;
      hdrValid <= 1'b0;
      hdrBytes <= 40'h0;
      cdValid <= 1'b0;
      cdData <= 8'h00;
      dataDone <= 1'b0;
      rdAddr <= 9'h000;
      c2tValid_reg <= 1'b0;
      c2tData_reg <= 8'h00;
      c2tEnd_reg <= 1'b0;
      c2tMore_reg <= 1'b0;
    end else if (ce) begin
      hdrValid <= 1'b0;
      cdValid <= 1'b0;
      dataDone <= 1'b0;
      c2tValid_reg <= 1'b0;
      c2tEnd_reg <= 1'b0;
      c2tMore_reg <= 1'b0;
      unique case (state_reg)
        C_HDR: begin
          if (link.t2cValid) begin
            cnt_reg <= cnt_reg + 9'd1;
            if (cnt_reg < 9'(HDR_BYTES)) begin
              hdrBytes <= {hdrBytes[31:0], link.t2cData};
            end else begin
              cdValid <= 1'b1;
              cdData <= link.t2cData;
            end
            if (useT1 && link.t2cEnd && !link.t2cMore) begin
              // a four byte message gains a zero length byte
              if (cnt_reg == 9'd3) begin
                hdrBytes <= {hdrBytes[23:0], link.t2cData, 8'h00};
              end
              cnt_reg <= 9'h000;
              hdrValid <= 1'b1;
              state_reg <= C_T1APP;
            end else if (!useT1 && cnt_reg == 9'(HDR_BYTES - 1)) begin
              cnt_reg <= 9'h000;
              base_reg <= (hdrBytes[23:16] == INS_GETRSP) ? base_reg : 9'h000;
              if (hdrBytes[23:16] == INS_GETRSP && pendLen_reg != 9'h000) begin
                // retrieval served as case 2 from the held response
                avail_reg <= pendLen_reg;
                sw_reg <= pendSw_reg;
                state_reg <= C_DEC;
              end else begin
                pendLen_reg <= 9'h000;
                hdrValid <= 1'b1;
                state_reg <= C_APP;
              end
            end
          end
        end
        C_APP: begin
          if (ansValid) begin
            caseNum_reg <= ansCase;
            sw_reg <= ansSw;
            avail_reg <= ansLen;
            if (ansCase == 3'd2) begin
              state_reg <= C_DEC;
            end else if (ansCase >= 3'd3 && ansSw == SW_OK) begin
              tx_reg <= {hdrBytes[31:24], 8'h00};
              txTwo_reg <= 1'b0;
              left_reg <= 9'(hdrBytes[7:0]);
              txNext_reg <= C_DIN;
              state_reg <= C_TX;
            end else begin
              tx_reg <= ansSw;
              txTwo_reg <= 1'b1;
              txNext_reg <= C_HDR;
              state_reg <= C_TX;
            end
          end
        end
        C_DEC: begin
          txNext_reg <= C_HDR;
          txTwo_reg <= 1'b1;
          state_reg <= C_TX;
          if (avail_reg == 9'h000 || !keepsData(sw_reg)) begin
            tx_reg <= sw_reg;
            pendLen_reg <= 9'h000;
          end else if ((hdrBytes[7:0] == 8'h00 && avail_reg < 9'h100) || le > avail_reg) begin
            tx_reg <= {PB_RELEN, avail_reg[7:0]};
          end else begin
            // acknowledge then stream le bytes
            tx_reg <= {hdrBytes[31:24], 8'h00};
            txTwo_reg <= 1'b0;
            left_reg <= le;
            rdAddr <= base_reg;
            txNext_reg <= C_DOUT;
            if (le == avail_reg) begin
              tail_reg <= sw_reg;
              pendLen_reg <= 9'h000;
            end else begin
              tail_reg <= {PB_MORE, 8'(avail_reg - le)};
              pendLen_reg <= avail_reg - le;
              pendSw_reg <= sw_reg;
              base_reg <= base_reg + le;
            end
          end
        end
        C_DIN: begin
          if (link.t2cValid) begin
            cdValid <= 1'b1;
            cdData <= link.t2cData;
            left_reg <= left_reg - 9'd1;
            if (left_reg == 9'd1) begin
              dataDone <= 1'b1;
              state_reg <= C_FIN;
            end
          end
        end
        C_FIN: begin
          if (ansValid) begin
            txTwo_reg <= 1'b1;
            txNext_reg <= C_HDR;
            state_reg <= C_TX;
            base_reg <= 9'h000;
            if (caseNum_reg == 3'd4 && ansSw == SW_OK) begin
              tx_reg <= {PB_MORE, ansLen[7:0]};
              pendLen_reg <= ansLen;
              pendSw_reg <= SW_OK;
            end else begin
              tx_reg <= ansSw;
              pendLen_reg <= (caseNum_reg == 3'd4 && keepsData(ansSw)) ? ansLen : 9'h000;
              pendSw_reg <= ansSw;
            end
          end
        end
        C_DOUT: begin
          c2tValid_reg <= 1'b1;
          c2tData_reg <= rdData;
          rdAddr <= rdAddr + 9'd1;
          left_reg <= left_reg - 9'd1;
          if (left_reg == 9'd1) begin
            tx_reg <= tail_reg;
            txTwo_reg <= 1'b1;
            txNext_reg <= C_HDR;
            state_reg <= C_TX;
          end
        end
        C_TX: begin
          // one or two bytes, high byte first
          c2tValid_reg <= 1'b1;
          c2tData_reg <= tx_reg[15:8];
          tx_reg <= {tx_reg[7:0], 8'h00};
          txTwo_reg <= 1'b0;
          if (!txTwo_reg) begin
            state_reg <= txNext_reg;
          end
        end
        C_T1APP: begin
          if (ansValid) begin
            sw_reg <= ansSw;
            avail_reg <= keepsData(ansSw) ? ansLen : 9'h000;
            cnt_reg <= 9'h000;
            blk_reg <= 9'h000;
            rdAddr <= 9'h000;
            state_reg <= C_T1TX;
          end
        end
        C_T1TX: begin
          c2tValid_reg <= 1'b1;
          if (cnt_reg < avail_reg) begin
            c2tData_reg <= rdData;
          end else begin
            c2tData_reg <= (cnt_reg == avail_reg) ? sw_reg[15:8] : sw_reg[7:0];
          end
          rdAddr <= rdAddr + 9'd1;
          cnt_reg <= cnt_reg + 9'd1;
          blk_reg <= blk_reg + 9'd1;
          if (blk_reg == 9'(BLK_LEN - 1) || cnt_reg == avail_reg + 9'd1) begin
            c2tEnd_reg <= 1'b1;
            c2tMore_reg <= (cnt_reg != avail_reg + 9'd1);
            blk_reg <= 9'h000;
          end
          if (cnt_reg == avail_reg + 9'd1) begin
            cnt_reg <= 9'h000;
            state_reg <= C_HDR;
          end
        end
        default: begin
          state_reg <= C_HDR;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** hdl/apt_pkg.sv ***
// shared constants and helpers for the message transport link
// assumes both ends and the bench compile this package first
package apt_pkg;

  // procedure bytes and instruction codes on the character protocol
  localparam logic [7:0] PB_NULL = 8'h60;
  localparam logic [7:0] PB_MORE = 8'h61;
  localparam logic [7:0] PB_RELEN = 8'h6c;
  localparam logic [7:0] INS_GETRSP = 8'hc0;

  // status words
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_BADLEN = 16'h6700;

  // sizes
  localparam int HDR_BYTES = 5;
  localparam int MAX_APDU = 261;
  localparam int BLK_MAX = 32;

  // warning, application or success status: data may travel with it
  function automatic logic keepsData(input logic [15:0] sw);
    keepsData = (sw[15:8] == 8'h62) || (sw[15:8] == 8'h63) || (sw[15:12] == 4'h9);
  endfunction

  // a length byte of zero asks for 256 bytes
  function automatic logic [8:0] leOf(input logic [7:0] p3);
    leOf = (p3 == 8'h00) ? 9'h100 : {1'b0, p3};
  endfunction

endpackage

// *** hdl/apt_link_if.sv ***
// byte link between the terminal end and the card end
// assumes both ends share one clock; the bench instantiates it
`timescale 1ns/1ps
`default_nettype none
interface apt_link_if;
  // terminal to card: byte strobe, data, block end, chain flag
  logic t2cValid;
  logic [7:0] t2cData;
  logic t2cEnd;
  logic t2cMore;
  // card to terminal
  logic c2tValid;
  logic [7:0] c2tData;
  logic c2tEnd;
  logic c2tMore;

  modport term (
    output t2cValid, t2cData, t2cEnd, t2cMore,
    input c2tValid, c2tData, c2tEnd, c2tMore
  );
  modport card (
    input t2cValid, t2cData, t2cEnd, t2cMore,
    output c2tValid, c2tData, c2tEnd, c2tMore
  );
endinterface
`default_nettype wire

// *** hdl/apt_terminal.sv ***
// terminal end: takes a command message from the application, carries it
// to the card and hands back response data and status
// assumes the card end sits on the same clock across apt_link_if
`timescale 1ns/1ps
`default_nettype none

// How it works
// - card passes case 2 through, data then status
// - case 3 data length must be 1 to 255
// - send data under procedure bytes, stop on status
// - case 3 card gives status after all data
// - case 4 drops trailing expected length byte
// - case 4 card answers 61xx or status
// - on 61xx send GET RESPONSE, P3 at most xx
// - case 4 warning status: GET RESPONSE length zero
// - other case 4 status ends the command
// - GET RESPONSE runs as a case 2 command
// - on 6Cxx resend header with P3 = xx
// - card uses 61/6C only for case 2, 4
// - case 2 wrong length: card answers 6C length
// - case 2 exact length: data then status
// - case 2 short length: data then 61xx
// - case 4 card gives 61 maximum or status
// - block protocol carries messages unchanged in blocks
// - block protocol data only with keeping statuses
// - terminal joins chained response blocks
// - terminal may chain command over several blocks
// - chain flag 1 means another block follows
// - terminal ends on status, not on 61/6C
module apt_terminal
  import apt_pkg::*;
#(
  parameter int BLK_LEN = BLK_MAX
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // protocol select: low for character protocol, high for block protocol
  input wire logic useT1,
  // command message from the application, one byte a cycle
  input wire logic cmdValid,
  input wire logic [7:0] cmdData,
  input wire logic cmdLast,
  output logic cmdBusy,
  // response message to the application
  output logic rspValid,
  output logic [7:0] rspData,
  output logic rspDone,
  output logic [15:0] rspSw,
  // link to the card end
  apt_link_if.term link
);

  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_START = 3'b001,
    T_HDR = 3'b010,
    T_PROC = 3'b011,
    T_OUT = 3'b100,
    T_IN = 3'b101,
    T_T1TX = 3'b110,
    T_T1RX = 3'b111
  } apt_tstate_t;

  apt_tstate_t state_reg;
  logic [7:0] mem [0:MAX_APDU-1];
  logic [8:0] len_reg;
  logic [2:0] caseNum_reg;
  logic [39:0] hdr_reg;
  logic [8:0] idx_reg;
  logic [8:0] blkCnt_reg;
  logic [8:0] inLeft_reg;
  logic [7:0] sw1_reg;
  logic haveSw1_reg;
  logic getRsp_reg;
  logic sent_reg;
  logic [15:0] hold_reg;
  logic [1:0] holdN_reg;
  logic t2cValid_reg;
  logic [7:0] t2cData_reg;
  logic t2cEnd_reg;
  logic t2cMore_reg;
  logic [7:0] lc;
  logic [8:0] lastIdx;
  logic [15:0] swNow;

  assign link.t2cValid = t2cValid_reg;
  assign link.t2cData = t2cData_reg;
  assign link.t2cEnd = t2cEnd_reg;
  assign link.t2cMore = t2cMore_reg;

  assign lc = mem[4];
  assign lastIdx = len_reg - 9'd1;
  assign swNow = {sw1_reg, link.c2tData};

  // command capture; bytes beyond the store are dropped, the length saturates
  always_ff @(posedge clk) begin
    if (reset) begin
      len_reg <= 9'h000;
    end else if (ce && cmdValid && !cmdBusy) begin
      if (rspDone) begin
        // a byte in the closing cycle opens the next command
        mem[0] <= cmdData;
        len_reg <= 9'd1;
      end else if (len_reg < 9'(MAX_APDU)) begin
        mem[len_reg] <= cmdData;
        len_reg <= len_reg + 9'd1;
      end
    end else if (ce && rspDone) begin
      len_reg <= 9'h000;
    end
  end

  // sequencer for both protocols
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= T_IDLE;
      cmdBusy <= 1'b0;
      rspValid <= 1'b0;
      rspData <= 8'h00;
      rspDone <= 1'b0;
      rspSw <= 16'h0000;
      caseNum_reg <= 3'd0;
      hdr_reg <= 40'h0;
      idx_reg <= 9'h000;
      blkCnt_reg <= 9'h000;
      inLeft_reg <= 9'h000;
      sw1_reg <= 8'h00;
      haveSw1_reg <= 1'b0;
      getRsp_reg <= 1'b0;
      sent_reg <= 1'b0;
      hold_reg <= 16'h0000;
      holdN_reg <= 2'd0;
      t2cValid_reg <= 1'b0;
      t2cData_reg <= 8'h00;
      t2cEnd_reg <= 1'b0;
      t2cMore_reg <= 1'b0;
    end else if (ce) begin
      rspValid <= 1'b0;
      rspDone <= 1'b0;
      t2cEnd_reg <= 1'b0;
      t2cMore_reg <= 1'b0;
      t2cValid_reg <= 1'b0;
      unique case (state_reg)
        T_IDLE: begin
          if (cmdValid && cmdLast && !cmdBusy) begin
            cmdBusy <= 1'b1;
            state_reg <= T_START;
          end
        end
        T_START: begin
          idx_reg <= 9'h000;
          blkCnt_reg <= 9'h000;
          getRsp_reg <= 1'b0;
          sent_reg <= 1'b0;
          haveSw1_reg <= 1'b0;
          holdN_reg <= 2'd0;
          if (useT1) begin
            state_reg <= T_T1TX;
          end else if (len_reg == 9'd4) begin
            // case 1 gains a zero length byte
            caseNum_reg <= 3'd1;
            hdr_reg <= {mem[0], mem[1], mem[2], mem[3], 8'h00};
            state_reg <= T_HDR;
          end else if (len_reg == 9'd5) begin
            caseNum_reg <= 3'd2;
            hdr_reg <= {mem[0], mem[1], mem[2], mem[3], lc};
            state_reg <= T_HDR;
          end else if (lc != 8'h00 && len_reg == 9'(lc) + 9'd5) begin
            caseNum_reg <= 3'd3;
            hdr_reg <= {mem[0], mem[1], mem[2], mem[3], lc};
            state_reg <= T_HDR;
          end else if (lc != 8'h00 && len_reg == 9'(lc) + 9'd6) begin
            // the trailing byte is simply never sent
            caseNum_reg <= 3'd4;
            hdr_reg <= {mem[0], mem[1], mem[2], mem[3], lc};
            state_reg <= T_HDR;
          end else begin
            // malformed length: refused without touching the link
            rspSw <= SW_BADLEN;
            rspDone <= 1'b1;
            cmdBusy <= 1'b0;
            state_reg <= T_IDLE;
          end
        end
        T_HDR: begin
          // rotate so the header is intact again after five bytes
          t2cValid_reg <= 1'b1;
          t2cData_reg <= hdr_reg[39:32];
          hdr_reg <= {hdr_reg[31:0], hdr_reg[39:32]};
          idx_reg <= idx_reg + 9'd1;
          if (idx_reg == 9'(HDR_BYTES - 1)) begin
            state_reg <= T_PROC;
            haveSw1_reg <= 1'b0;
          end
        end
        T_PROC: begin
          if (link.c2tValid && haveSw1_reg) begin
            haveSw1_reg <= 1'b0;
            idx_reg <= 9'h000;
            if (sw1_reg == PB_MORE) begin
              // fetch the rest; P3 equals xx
              hdr_reg <= {hdr_reg[39:32], INS_GETRSP, 16'h0000, link.c2tData};
              getRsp_reg <= 1'b1;
              state_reg <= T_HDR;
            end else if (sw1_reg == PB_RELEN) begin
              hdr_reg <= {hdr_reg[39:8], link.c2tData};
              state_reg <= T_HDR;
            end else if (caseNum_reg == 3'd4 && sent_reg && !getRsp_reg && keepsData(swNow)
                         && swNow != SW_OK) begin
              hdr_reg <= {hdr_reg[39:32], INS_GETRSP, 24'h000000};
              getRsp_reg <= 1'b1;
              state_reg <= T_HDR;
            end else begin
              // any other status closes the command
              rspSw <= swNow;
              rspDone <= 1'b1;
              cmdBusy <= 1'b0;
              state_reg <= T_IDLE;
            end
          end else if (link.c2tValid && link.c2tData == PB_NULL) begin
            state_reg <= T_PROC;
          end else if (link.c2tValid && link.c2tData == hdr_reg[31:24]) begin
            if (caseNum_reg >= 3'd3 && !getRsp_reg && !sent_reg) begin
              idx_reg <= 9'd5;
              state_reg <= T_OUT;
            end else begin
              inLeft_reg <= leOf(hdr_reg[7:0]);
              state_reg <= T_IN;
            end
          end else if (link.c2tValid) begin
            sw1_reg <= link.c2tData;
            haveSw1_reg <= 1'b1;
          end
        end
        T_OUT: begin
          t2cValid_reg <= 1'b1;
          t2cData_reg <= mem[idx_reg];
          idx_reg <= idx_reg + 9'd1;
          if (idx_reg == 9'(hdr_reg[7:0]) + 9'd4) begin
            sent_reg <= 1'b1;
            state_reg <= T_PROC;
          end
        end
        T_IN: begin
          if (link.c2tValid) begin
            rspValid <= 1'b1;
            rspData <= link.c2tData;
            inLeft_reg <= inLeft_reg - 9'd1;
            if (inLeft_reg == 9'd1) begin
              state_reg <= T_PROC;
            end
          end
        end
        T_T1TX: begin
          // whole message, cut into blocks of BLK_LEN and chained
          t2cValid_reg <= 1'b1;
          t2cData_reg <= mem[idx_reg];
          idx_reg <= idx_reg + 9'd1;
          blkCnt_reg <= blkCnt_reg + 9'd1;
          if (blkCnt_reg == 9'(BLK_LEN - 1) || idx_reg == lastIdx) begin
            t2cEnd_reg <= 1'b1;
            t2cMore_reg <= (idx_reg != lastIdx);
            blkCnt_reg <= 9'h000;
          end
          if (idx_reg == lastIdx) begin
            state_reg <= T_T1RX;
          end
        end
        T_T1RX: begin
          // two bytes held back so the trailing status is not sent as data
          if (link.c2tValid) begin
            hold_reg <= {hold_reg[7:0], link.c2tData};
            if (holdN_reg == 2'd2) begin
              rspValid <= 1'b1;
              rspData <= hold_reg[15:8];
            end else begin
              holdN_reg <= holdN_reg + 2'd1;
            end
            if (link.c2tEnd && !link.c2tMore) begin
              rspSw <= {hold_reg[7:0], link.c2tData};
              rspDone <= 1'b1;
              cmdBusy <= 1'b0;
              state_reg <= T_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** bench/apt_link_asserts.sv ***
// link checker: watches both directions of the byte link
// assumes one clock, sync high reset, instanced once beside the link
`timescale 1ns/1ps
`default_nettype none
module apt_link_asserts
  import apt_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // link signals
  input wire logic t2cValid,
  input wire logic [7:0] t2cData,
  input wire logic t2cEnd,
  input wire logic t2cMore,
  input wire logic c2tValid,
  input wire logic [7:0] c2tData,
  input wire logic c2tEnd,
  input wire logic c2tMore
);
  logic [7:0] lastReg;
  logic [7:0] kindReg;
  logic [7:0] xxReg;
  logic [7:0] cntReg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // last procedure pair; relies on bench data never looking like 61 or 6c
  always_ff @(posedge clk) begin
    if (reset) begin
      lastReg <= 8'h00;
      kindReg <= 8'h00;
      xxReg <= 8'h00;
    end else if (c2tValid) begin
      lastReg <= c2tData;
      kindReg <= (lastReg == PB_MORE || lastReg == PB_RELEN) ? lastReg : 8'h00;
      xxReg <= c2tData;
    end
  end
  // terminal bytes since the last card byte
  always_ff @(posedge clk) begin
    if (reset || c2tValid) begin
      cntReg <= 8'h00;
    end else if (t2cValid) begin
      cntReg <= cntReg + 8'h01;
    end
  end
  AST_T2C_END: assert property (t2cEnd |-> t2cValid)
    else $error("terminal block end without byte");
  AST_C2T_END: assert property (c2tEnd |-> c2tValid)
    else $error("card block end without byte");
  AST_HALF: assert property (t2cValid |-> !c2tValid)
    else $error("both ends sent in one cycle");
  AST_T2C_CHAIN: assert property (t2cEnd && t2cMore |-> ##[1:50] t2cValid)
    else $error("terminal chain broken");
  AST_C2T_CHAIN: assert property (c2tEnd && c2tMore |-> ##[1:50] c2tValid)
    else $error("card chain broken");
  AST_GR_INS: assert property (t2cValid && kindReg == PB_MORE && cntReg == 8'h01 |->
    t2cData == INS_GETRSP) else $error("no retrieval after more-data");
  AST_GR_LEN: assert property (t2cValid && kindReg == PB_MORE && cntReg == 8'h04 &&
    xxReg != 8'h00 |-> t2cData <= xxReg) else $error("retrieval too long");
  AST_RELEN: assert property (t2cValid && kindReg == PB_RELEN && cntReg == 8'h04 |->
    t2cData == xxReg) else $error("resent length wrong");
endmodule
`default_nettype wire

// *** bench/test_apdu_transport_mapping.sv ***
// bench: both ends joined by the link; bench is host and card application
// assumes the card reads rdData combinationally from rdAddr
`timescale 1ns/1ps
`default_nettype none
module test_apdu_transport_mapping
  import apt_pkg::*;
;
  typedef struct packed {
    logic t1; logic [2:0] cs; logic [7:0] lc, le; logic [15:0] sw1, sw;
    logic [8:0] len; logic [15:0] expSw; logic [8:0] expN;
  } apt_row_t;
  logic clk = 1'b0, reset = 1'b1, useT1 = 1'b0, cmdValid = 1'b0, cmdLast = 1'b0;
  logic ansValid = 1'b0, cmdBusy, rspValid, rspDone, hdrValid, cdValid, dataDone;
  logic [7:0] cmdData = 8'h00, rspData, cdData, rdData;
  logic [2:0] ansCase = 3'h0;
  logic [15:0] ansSw = 16'h0000, rspSw;
  logic [8:0] ansLen = 9'h000, rdAddr;
  logic [39:0] hdrBytes;
  int badCount = 0, checked = 0, cyc = 0, rspN, cdN, hdrN, blkN, curI, curN;
  apt_row_t r;
  apt_row_t rows [11];
  apt_link_if link ();
  apt_terminal #(.BLK_LEN(4)) u_apt_terminal (.clk(clk), .reset(reset), .ce(1'b1),
    .useT1(useT1), .cmdValid(cmdValid), .cmdData(cmdData), .cmdLast(cmdLast),
    .cmdBusy(cmdBusy), .rspValid(rspValid), .rspData(rspData), .rspDone(rspDone),
    .rspSw(rspSw), .link(link));
  apt_card #(.BLK_LEN(4)) u_apt_card (.clk(clk), .reset(reset), .ce(1'b1), .useT1(useT1),
    .link(link), .hdrValid(hdrValid), .hdrBytes(hdrBytes), .cdValid(cdValid),
    .cdData(cdData), .dataDone(dataDone), .ansValid(ansValid), .ansCase(ansCase),
    .ansSw(ansSw), .ansLen(ansLen), .rdAddr(rdAddr), .rdData(rdData));
  apt_link_asserts u_apt_link_asserts (.clk(clk), .reset(reset),
    .t2cValid(link.t2cValid), .t2cData(link.t2cData), .t2cEnd(link.t2cEnd),
    .t2cMore(link.t2cMore), .c2tValid(link.c2tValid), .c2tData(link.c2tData),
    .c2tEnd(link.c2tEnd), .c2tMore(link.c2tMore));
  // response store: a fixed pattern on rdAddr[7:0] so byte positions within any 256 are told apart
  assign rdData = rdAddr[7:0] ^ 8'h5a;
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic endOfTest();
    $display("checked %0d bad %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [7:0] cmdByte(input int k, input int n);
    if (k < 4) return (k == 0) ? 8'h00 : (k == 1) ? 8'ha0 + 8'(curI) : (k == 2) ? 8'h11 : 8'h22;
    if (k == n - 1 && r.cs == 3'h4) return r.le;
    if (k == 4) return (r.cs == 3'h2) ? r.le : r.lc;
    return 8'h30 + 8'(k - 5);
  endfunction
  task automatic runRow(input int i);
    int n;
    int w;
    curI = i;
    r = rows[i];
    n = (r.cs == 3'h1) ? 4 : (r.cs == 3'h2) ? 5 : (r.cs == 3'h5) ? 6 : 5 + r.lc + (r.cs == 3'h4);
    curN = n;
    rspN = 0;
    cdN = 0;
    hdrN = 0;
    blkN = 0;
    useT1 = r.t1;
    repeat (2) @(negedge clk);
    for (int k = 0; k < n; k++) begin
      cmdValid = 1'b1;
      cmdData = cmdByte(k, n);
      cmdLast = (k == n - 1);
      @(negedge clk);
    end
    cmdValid = 1'b0;
    cmdLast = 1'b0;
    w = 0;
    while (rspDone !== 1'b1 && w < 3000) begin
      @(negedge clk);
      w++;
    end
    check("done", 40'(w < 3000), 40'(1));
    @(negedge clk);
    check("sw", 40'(rspSw), 40'(r.expSw));
    check("count", 40'(rspN), 40'(r.expN));
    check("hdrs", 40'(hdrN != 0), 40'(r.cs != 3'h5));
    if (r.t1) check("blocks", 40'(blkN), 40'((n + 3) / 4));
    else check("cdata", 40'(cdN), 40'((r.cs == 3'h3 || r.cs == 3'h4) && r.sw1 == SW_OK ? r.lc : 0));
  endtask
  // card application and response watcher, all on the falling edge
  always @(negedge clk) begin
    ansValid <= (hdrValid === 1'b1 && hdrBytes[31:24] != INS_GETRSP) || dataDone === 1'b1;
    if (rspValid === 1'b1) begin
      check("data", 40'(rspData), 40'(8'(rspN) ^ 8'h5a));
      rspN++;
    end
    if (cdValid === 1'b1) begin
      check("cd", 40'(cdData), 40'(cmdByte(cdN + 5, curN)));
      cdN++;
    end
    if (link.t2cEnd === 1'b1) blkN++;
    if (hdrValid === 1'b1 && hdrBytes[31:24] != INS_GETRSP) begin
      if (hdrN == 0) check("hdr", hdrBytes, {8'h00, 8'ha0 + 8'(curI), 16'h1122, cmdByte(4, 9)});
      hdrN++;
      ansCase <= r.cs;
      ansSw <= (r.cs > 3'h2 && !r.t1) ? r.sw1 : r.sw;
      ansLen <= r.len;
    end
    if (dataDone === 1'b1) begin
      ansSw <= r.sw;
    end
  end
  // hang guard: far above the few hundred cycles the rows need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      badCount++;
      endOfTest();
    end
  end
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    rows = '{
      '{1'b0, 3'h1, 8'h00, 8'h00, SW_OK, SW_OK, 9'h000, SW_OK, 9'h000},
      '{1'b0, 3'h2, 8'h00, 8'h04, SW_OK, SW_OK, 9'h004, SW_OK, 9'h004},
      '{1'b0, 3'h2, 8'h00, 8'h08, SW_OK, SW_OK, 9'h004, SW_OK, 9'h004},
      '{1'b0, 3'h3, 8'h03, 8'h00, SW_OK, SW_OK, 9'h000, SW_OK, 9'h000},
      '{1'b0, 3'h3, 8'h03, 8'h00, 16'h6a82, 16'h6a82, 9'h000, 16'h6a82, 9'h000},
      '{1'b0, 3'h4, 8'h02, 8'h03, SW_OK, SW_OK, 9'h003, SW_OK, 9'h003},
      '{1'b0, 3'h4, 8'h02, 8'h00, SW_OK, 16'h6283, 9'h002, 16'h6283, 9'h002},
      '{1'b0, 3'h4, 8'h02, 8'h03, SW_OK, 16'h6a80, 9'h003, 16'h6a80, 9'h000},
      '{1'b0, 3'h5, 8'h03, 8'h00, SW_OK, SW_OK, 9'h000, SW_BADLEN, 9'h000},
      '{1'b1, 3'h2, 8'h00, 8'h06, SW_OK, SW_OK, 9'h006, SW_OK, 9'h006},
      '{1'b1, 3'h4, 8'h05, 8'h02, SW_OK, 16'h6a80, 9'h002, 16'h6a80, 9'h000}
    };
    repeat (8) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 11; i++) runRow(i);
    // second reset after a block run must clear busy, the strobes, done and rspSw
    reset = 1'b1;
    repeat (2) @(negedge clk);
    check("rst", 40'({cmdBusy, rspValid, rspDone, hdrValid, link.t2cValid, link.c2tValid}), 40'(0));
    check("rstsw", 40'(rspSw), 40'(0));
    reset = 1'b0;
    runRow(5);
    endOfTest();
  end
endmodule
`default_nettype wire
